// ---- rtl/tcm_channel.sv ----
// One timer channel: mode logic, counter, capture and waveform lines, APB slave
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
module tcm_channel
  import tcm_pkg::*;
(
  input  wire logic         sys_clk,   // 25 MHz master clock
  input  wire logic         rst_n,     // Synchronous reset, active low
  input  wire logic         psel,      // APB select
  input  wire logic         penable,   // APB access phase
  input  wire logic         pwrite,    // APB direction
  input  wire logic [7:0]   paddr,     // APB byte address
  input  wire logic [31:0]  pwdata,    // APB write data
  output logic [31:0]       prdata,    // APB read data
  output logic              pready,    // APB ready
  output logic              pslverr,   // APB error
  input  wire tcm_pins_t    pins,      // External clocks and line inputs
  output tcm_drive_t        drive      // Line outputs and enables
);

  tcm_state_t s_q;
  tcm_state_t s_d;

  // Edge detection of a sampled level against its previous value
  function automatic logic edgeHit(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = ~cur & prev;
    unique case (sel)
      EDGE_NONE: edgeHit = 1'b0;
      EDGE_RISE: edgeHit = rise;
      EDGE_FALL: edgeHit = fall;
      default:   edgeHit = rise | fall;
    endcase
  endfunction

  // Line action: none, set, clear, toggle
  function automatic logic lineAct(input logic [1:0] act, input logic hit, input logic cur);
    lineAct = cur;
    if (hit)
    begin
      unique case (act)
        ACT_SET: lineAct = 1'b1;
        ACT_CLR: lineAct = 1'b0;
        ACT_TOG: lineAct = ~cur;
        default: lineAct = cur;
      endcase
    end
  endfunction

  // Pick one of the external clocks by a two-bit code, code 0 gives fallback
  function automatic logic extPick(input logic [1:0] sel, input logic fb, input tcm_pins_t p);
    unique case (sel)
      2'h0:    extPick = fb;
      2'h1:    extPick = p.ext_clock_0;
      2'h2:    extPick = p.ext_clock_1;
      default: extPick = p.ext_clock_2;
    endcase
  endfunction

  logic        selClk;
  logic        gatedClk;
  logic        countTick;
  logic        capMode;
  logic        waveMode;
  logic        trigSrc;
  logic        extTrig;
  logic        evtSrc;
  logic        evtHit;
  logic        matchA;
  logic        matchB;
  logic        matchC;
  logic        softTrig;
  logic        busWrite;
  logic        busRead;
  logic        anyTrig;
  logic        mapped;
  logic [31:0] rdata;
  logic [15:0] nextCount;

  // Counter clock selection, inversion and gating
  always_comb
  begin
    unique case (s_q.mode.count_clock_source)   // [RL7]
      3'h0:    selClk = s_q.pre[TAP0];
      3'h1:    selClk = s_q.pre[TAP1];
      3'h2:    selClk = s_q.pre[TAP2];
      3'h3:    selClk = s_q.pre[TAP3];
      3'h4:    selClk = s_q.pre[TAP4];
      3'h5:    selClk = pins.ext_clock_0;
      3'h6:    selClk = pins.ext_clock_1;
      default: selClk = pins.ext_clock_2;
    endcase
    gatedClk = (selClk ^ s_q.mode.clock_invert)                                  // [RL8]
             & extPick(s_q.mode.clock_gate_sel, 1'b1, pins);                    // [RL9]
    countTick = gatedClk & ~s_q.clkPrev & s_q.clkOn & ~s_q.halted;
  end

  // Mode decode, trigger, event and compare matches
  always_comb
  begin
    waveMode = s_q.mode.wave_mode;                         // [RL4]
    capMode  = ~waveMode;
    trigSrc  = s_q.mode.event_source_sel[0] ? pins.io_line_a : pins.io_line_b;  // [RL2]
    extTrig  = capMode & edgeHit(s_q.mode.event_edge_sel, s_q.trigPrev, trigSrc);  // [RL1]
    evtSrc   = extPick(s_q.mode.event_source_sel, pins.io_line_b, pins);         // [RL13]
    evtHit   = waveMode & edgeHit(s_q.mode.event_edge_sel, s_q.evtPrev, evtSrc); // [RL12]
    matchA   = waveMode & countTick & (s_q.count == s_q.capA);
    matchB   = waveMode & countTick & (s_q.count == s_q.capB);
    matchC   = countTick & (s_q.count == s_q.cmpC);
    busWrite = psel & penable & pwrite & ~s_q.rsp.pready;
    busRead  = psel & penable & ~pwrite & ~s_q.rsp.pready;
    softTrig = busWrite & (paddr == ADDR_CTRL) & pwdata[CMD_SOFT];
    anyTrig  = softTrig | extTrig
             | (evtHit & s_q.mode.event_restart_en)          // [RL15]
             | (matchC & s_q.mode.c_match_restart);          // [RL3]
    nextCount = s_q.count + 16'h0001;                        // [RL22]
  end

  // Register read decode
  always_comb
  begin
    mapped = 1'b1;
    rdata  = 32'h0000_0000;
    unique case (paddr)
      ADDR_CTRL:  rdata = 32'h0000_0000;
      ADDR_MODE:  rdata = s_q.mode;
      ADDR_COUNT: rdata = {16'h0000, s_q.count};             // [RL18]
      ADDR_REGA:  rdata = {16'h0000, s_q.capA};
      ADDR_REGB:  rdata = {16'h0000, s_q.capB};
      ADDR_REGC:  rdata = {16'h0000, s_q.cmpC};
      default:    mapped = 1'b0;
    endcase
  end

  // Next state of the whole channel
  always_comb
  begin
    s_d = s_q;
    s_d.pre      = s_q.pre + {{(PRE_W-1){1'b0}}, 1'b1};
    s_d.clkPrev  = gatedClk;
    s_d.trigPrev = trigSrc;
    s_d.ldPrev   = pins.io_line_a;
    s_d.evtPrev  = evtSrc;

    // Counter increment and wrap; a halting compare-C match holds the count at C
    if (countTick & ~(matchC & waveMode & (s_q.mode.c_match_halt | s_q.mode.c_match_clock_off)))
      s_d.count = nextCount;                                 // [RL22]

    // Compare-C halt and clock-off in waveform mode
    if (matchC & waveMode & s_q.mode.c_match_halt)
      s_d.halted = 1'b1;                                     // [RL10]
    if (matchC & waveMode & s_q.mode.c_match_clock_off)
      s_d.clkOn = 1'b0;                                      // [RL11]

    // Triggers reset the counter and release a halt; a disabled clock waits for clock-on
    if (anyTrig)
    begin
      s_d.count  = 16'h0000;                                 // [RL19]
      s_d.halted = 1'b0;                                     // [RL21]
    end

    // Capture loads on line A edges
    if (capMode & edgeHit(s_q.mode.line_a_on_match_a, s_q.ldPrev, pins.io_line_a))
      s_d.capA = s_q.count;                                  // [RL5]
    if (capMode & edgeHit(s_q.mode.line_a_on_match_c, s_q.ldPrev, pins.io_line_a))
      s_d.capB = s_q.count;                                  // [RL6]

    // Waveform line A effects, match A lowest then compare C, event, soft trigger
    s_d.lineA = lineAct(s_q.mode.line_a_on_match_a, matchA, s_q.lineA);           // [RL16]
    s_d.lineA = lineAct(s_q.mode.line_a_on_match_c, matchC & waveMode, s_d.lineA);
    s_d.lineA = lineAct(s_q.mode.line_a_on_event, evtHit, s_d.lineA);
    s_d.lineA = lineAct(s_q.mode.line_a_on_soft_trig, softTrig & waveMode, s_d.lineA);
    // Waveform line B effects
    s_d.lineB = lineAct(s_q.mode.line_b_on_match_b, matchB, s_q.lineB);           // [RL17]
    s_d.lineB = lineAct(s_q.mode.line_b_on_match_c, matchC & waveMode, s_d.lineB);
    s_d.lineB = lineAct(s_q.mode.line_b_on_event, evtHit, s_d.lineB);
    s_d.lineB = lineAct(s_q.mode.line_b_on_soft_trig, softTrig & waveMode, s_d.lineB);

    // Pin drive: capture mode drives nothing, line B input when it is the event
    s_d.drive.line_a_out = s_d.lineA;
    s_d.drive.line_a_oe  = s_d.mode.wave_mode;
    s_d.drive.line_b_out = s_d.lineB;
    s_d.drive.line_b_oe  = s_d.mode.wave_mode & (s_d.mode.event_source_sel != EVT_LINE_B);  // [RL14]

    // APB slave, one wait state; answer in the cycle after access starts
    s_d.rsp.pready  = psel & penable & ~s_q.rsp.pready;
    s_d.rsp.pslverr = psel & penable & ~s_q.rsp.pready & ~mapped;
    s_d.rsp.prdata  = busRead ? rdata : 32'h0000_0000;
    if (busWrite & mapped)
    begin
      unique case (paddr)
        ADDR_CTRL:
        begin
          if (pwdata[CMD_CLK_OFF])
            s_d.clkOn = 1'b0;                                // [RL20]
          else if (pwdata[CMD_CLK_ON])
            s_d.clkOn = 1'b1;                                // [RL21]
        end
        ADDR_MODE: s_d.mode = tcm_mode_t'(pwdata);
        ADDR_REGA: if (waveMode) s_d.capA = pwdata[15:0];
        ADDR_REGB: if (waveMode) s_d.capB = pwdata[15:0];
        ADDR_REGC: s_d.cmpC = pwdata[15:0];
        default:   s_d.clkOn = s_d.clkOn;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_q      <= '0;
      s_q.mode <= tcm_mode_t'(MODE_RESET);
    end
    else
      s_q <= s_d;
  end

  assign prdata  = s_q.rsp.prdata;
  assign pready  = s_q.rsp.pready;
  assign pslverr = s_q.rsp.pslverr;
  assign drive   = s_q.drive;

endmodule

// ---- rtl/tcm_pkg.sv ----
// Package of constants and types for the timer channel mode logic
// Summary of operation
// [RL1] Trigger edge field: none, rise, fall, both
// [RL2] Trigger line bit: 0 line B, 1 line A
// [RL3] Compare-C restart bit resets and starts counter
// [RL4] Mode bit: 0 capture, 1 waveform
// [RL5] Line A edge loads capture register A
// [RL6] Line A edge loads capture register B
// [RL7] Clock source: divided master or external clocks
// [RL8] Invert bit picks rising or falling count edge
// [RL9] Gating field ANDs clock with external clock
// [RL10] Compare-C halt stops clock at match
// [RL11] Compare-C clock-off disables clock at match
// [RL12] Event edge field: none, rise, fall, both
// [RL13] Event source: line B or external clocks
// [RL14] Line B as event becomes input only
// [RL15] Event-restart bit lets event reset counter
// [RL16] Four fields drive line A: set/clear/toggle
// [RL17] Four fields drive line B: set/clear/toggle
// [RL18] Counter value register shows live count
// [RL19] Software trigger resets counter, releases halt
// [RL20] Clock-on works unless clock-off written too
// [RL21] Halt restarts on trigger; clock-off needs command
// [RL22] Counter wraps from maximum to zero
package tcm_pkg;
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;
  localparam logic [7:0]  ADDR_MODE   = 8'h04;
  localparam logic [7:0]  ADDR_COUNT  = 8'h10;
  localparam logic [7:0]  ADDR_REGA   = 8'h14;
  localparam logic [7:0]  ADDR_REGB   = 8'h18;
  localparam logic [7:0]  ADDR_REGC   = 8'h1C;
  localparam logic [31:0] MODE_RESET  = 32'h0000_0000;
  // Command bits of the control register
  localparam int CMD_CLK_ON  = 0;
  localparam int CMD_CLK_OFF = 1;
  localparam int CMD_SOFT    = 2;
  // Prescaler tap bits: half-period of divide 2,8,32,128,1024
  localparam int PRE_W = 10;
  localparam logic [3:0] TAP0 = 4'h0;
  localparam logic [3:0] TAP1 = 4'h2;
  localparam logic [3:0] TAP2 = 4'h4;
  localparam logic [3:0] TAP3 = 4'h6;
  localparam logic [3:0] TAP4 = 4'h9;
  // Edge select and line action codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] ACT_SET   = 2'h1;
  localparam logic [1:0] ACT_CLR   = 2'h2;
  localparam logic [1:0] ACT_TOG   = 2'h3;
  localparam logic [1:0] EVT_LINE_B = 2'h0;

  // Mode register in waveform layout; capture fields overlay it
  typedef struct packed {
    logic [1:0] line_b_on_soft_trig;  // 31:30
    logic [1:0] line_b_on_event;      // 29:28
    logic [1:0] line_b_on_match_c;    // 27:26
    logic [1:0] line_b_on_match_b;    // 25:24
    logic [1:0] line_a_on_soft_trig;  // 23:22
    logic [1:0] line_a_on_event;      // 21:20
    logic [1:0] line_a_on_match_c;    // 19:18
    logic [1:0] line_a_on_match_a;    // 17:16
    logic       wave_mode;            // 15
    logic       c_match_restart;      // 14
    logic       rsvd13;               // 13
    logic       event_restart_en;     // 12
    logic [1:0] event_source_sel;     // 11:10
    logic [1:0] event_edge_sel;       // 9:8
    logic       c_match_clock_off;    // 7
    logic       c_match_halt;         // 6
    logic [1:0] clock_gate_sel;       // 5:4
    logic       clock_invert;         // 3
    logic [2:0] count_clock_source;   // 2:0
  } tcm_mode_t;

  // Pin inputs of the channel
  typedef struct packed {
    logic ext_clock_0;
    logic ext_clock_1;
    logic ext_clock_2;
    logic io_line_a;
    logic io_line_b;
  } tcm_pins_t;

  // Pin outputs: values and output enables
  typedef struct packed {
    logic line_a_out;
    logic line_a_oe;
    logic line_b_out;
    logic line_b_oe;
  } tcm_drive_t;

  // APB completer response
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } tcm_apb_rsp_t;

  // Whole module state
  typedef struct packed {
    tcm_mode_t    mode;
    logic [15:0]  count;
    logic [15:0]  capA;
    logic [15:0]  capB;
    logic [15:0]  cmpC;
    logic         clkOn;
    logic         halted;
    logic [PRE_W-1:0] pre;
    logic         clkPrev;
    logic         trigPrev;
    logic         ldPrev;
    logic         evtPrev;
    logic         lineA;
    logic         lineB;
    tcm_drive_t   drive;
    tcm_apb_rsp_t rsp;
  } tcm_state_t;
endpackage

// ---- bench/tcm_channel_assertions.sv ----
// Port checker for the timer channel
`timescale 1ns/1ps
module tcm_channel_assertions
  import tcm_pkg::*;
(
  input wire logic        sys_clk,  // Clock
  input wire logic        rst_n,    // Reset, active low
  input wire logic        psel,     // APB select
  input wire logic        penable,  // APB access
  input wire logic        pwrite,   // APB direction
  input wire logic [7:0]  paddr,    // APB address
  input wire logic [31:0] pwdata,   // APB write data
  input wire logic [31:0] prdata,   // APB read data
  input wire logic        pready,   // APB ready
  input wire logic        pslverr,  // APB error
  input wire tcm_pins_t   pins,     // Pin inputs
  input wire tcm_drive_t  drive     // Pin outputs
);
  logic [5:0] modeSh_q;  // Mode bits 15:10 as last written
  logic       mapped;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the mode bits, taken at the same edge as the design
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      modeSh_q <= 6'h00;
    else if (psel && penable && pwrite && !pready && paddr == ADDR_MODE)
      modeSh_q <= pwdata[15:10];
  end
  // Address decode
  assign mapped = paddr inside {ADDR_CTRL, ADDR_MODE, ADDR_COUNT, ADDR_REGA, ADDR_REGB, ADDR_REGC};
  a_ready_pulse: assert property ($rose(penable) && psel |=> pready ##1 !pready)
    else $error("pready not a single pulse one cycle after access");
  a_ready_cause: assert property (pready |-> $past(psel && penable))
    else $error("pready without access phase");
  a_err_decode: assert property (pslverr |-> pready && !mapped)
    else $error("pslverr on mapped address or without pready");
  a_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped address answered with error");
  a_idle_data: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not zero outside ready");
  a_count_upper: assert property (pready && !pwrite && paddr == ADDR_COUNT |-> prdata[31:16] == 16'h0000)
    else $error("count upper bits not zero");
  a_capture_inputs: assert property (!modeSh_q[5] && !$past(modeSh_q[5], 2) |-> !drive.line_a_oe && !drive.line_b_oe)
    else $error("line driven in capture mode");
  a_wave_line_a: assert property (modeSh_q[5] && $past(modeSh_q, 2) == modeSh_q |-> drive.line_a_oe)
    else $error("line A not driven in waveform mode");
  a_line_b_input: assert property (
    modeSh_q[5] && modeSh_q[1:0] == EVT_LINE_B && $past(modeSh_q, 2) == modeSh_q |-> !drive.line_b_oe)
    else $error("line B driven while used as event input");
  a_line_b_output: assert property (
    modeSh_q[5] && modeSh_q[1:0] != EVT_LINE_B && $past(modeSh_q, 2) == modeSh_q |-> drive.line_b_oe)
    else $error("line B not driven with external clock event");
endmodule

bind tcm_channel tcm_channel_assertions u_tcm_channel_assertions (.sys_clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .drive);

// ---- bench/tcm_pins_model.sv ----
// Far-side pin model: external clocks and line inputs
`timescale 1ns/1ps
module tcm_pins_model
  import tcm_pkg::*;
(
  input  wire logic       sys_clk,  // Clock
  input  wire tcm_drive_t drive,    // Design line outputs
  output tcm_pins_t       pins      // Levels seen by the design
);
  logic [4:0] lvl_q = 5'h00;  // Far-side levels: clocks 0..2, line A, line B
  // A line follows the design while it drives, else the far side
  assign pins = {lvl_q[0], lvl_q[1], lvl_q[2], drive.line_a_oe ? drive.line_a_out : lvl_q[3],
                 drive.line_b_oe ? drive.line_b_out : lvl_q[4]};
  // Change one level just after an edge, then hold it four cycles
  task automatic setPin(input int idx, input logic val);
    @(posedge sys_clk);
    lvl_q[idx] <= val;
    repeat (4) @(posedge sys_clk);
  endtask
endmodule

// ---- bench/timer_channel_mode_logic_test.sv ----
// Self-checking bench for the timer channel mode logic
`timescale 1ns/1ps
module timer_channel_mode_logic_test
  import tcm_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [31:0] prdata, rdData, a, b;
  logic        pready, pslverr, err;
  tcm_pins_t   pins;
  tcm_drive_t  drive;
  int          fails = 0;
  int          n_compared = 0;
  logic [1:0]  codes[5] = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h3};
  logic        lvls[5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
  logic [31:0] extModes[3] = '{32'h5, 32'hD, 32'h25};
  tcm_channel u_tcm_channel (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pins, .drive);
  tcm_pins_model u_tcm_pins_model (.sys_clk, .drive, .pins);
  always #20 sys_clk = ~sys_clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    if (fails == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // One APB transfer; data and error taken at the ready edge
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      fails++;
    rdData = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reset values, read-write and unmapped access
  task automatic testRegs();
    xfer(0, ADDR_MODE, 0);
    check("mode reset", rdData, MODE_RESET);
    xfer(0, ADDR_COUNT, 0);
    check("count reset", rdData, 32'h0);
    xfer(0, 8'h08, 0);
    check("unmapped err", {31'h0, err}, 32'h1);
    xfer(1, ADDR_MODE, 32'h5A5A_C0F5);
    xfer(0, ADDR_MODE, 0);
    check("mode rw", rdData, 32'h5A5A_C0F5);
  endtask
  // Master divides: ticks over 128 cycles; clock on and off commands
  task automatic testRate();
    for (int c = 0; c < 4; c++)
    begin
      xfer(1, ADDR_MODE, c);
      xfer(1, ADDR_CTRL, 32'h5);
      xfer(0, ADDR_COUNT, 0);
      a = rdData;
      repeat (124) @(posedge sys_clk);
      xfer(0, ADDR_COUNT, 0);
      check("divide", {16'h0, rdData[15:0] - a[15:0]}, 32'd64 >> (2 * c));
    end
    xfer(1, ADDR_MODE, 32'h0);
    xfer(1, ADDR_CTRL, 32'h3);
    xfer(0, ADDR_COUNT, 0);
    a = rdData;
    repeat (20) @(posedge sys_clk);
    xfer(0, ADDR_COUNT, 0);
    check("on with off", rdData, a);
    xfer(1, ADDR_CTRL, 32'h1);
    repeat (8) @(posedge sys_clk);
    xfer(0, ADDR_COUNT, 0);
    check("clock on", {31'h0, rdData != a}, 32'h1);
  endtask
  // External clock 0 plain, inverted, and gated by a low clock 1
  task automatic testExt();
    for (int i = 0; i < 3; i++)
    begin
      xfer(1, ADDR_MODE, extModes[i]);
      xfer(1, ADDR_CTRL, 32'h4);
      xfer(0, ADDR_COUNT, 0);
      a = rdData;
      u_tcm_pins_model.setPin(0, 1'b1);
      xfer(0, ADDR_COUNT, 0);
      check("ext rise", rdData - a, {31'h0, i == 0});
      u_tcm_pins_model.setPin(0, 1'b0);
      xfer(0, ADDR_COUNT, 0);
      check("ext pulse", rdData - a, {31'h0, i < 2});
    end
  endtask
  // Software trigger effects on both lines, then line B as event input
  task automatic testLines();
    for (int i = 0; i < 5; i++)
    begin
      xfer(1, ADDR_MODE, 32'h8400 | (32'(codes[i]) << 22) | (32'(codes[i]) << 30));
      xfer(1, ADDR_CTRL, 32'h4);
      repeat (3) @(posedge sys_clk);
      check("lines", {28'h0, drive}, {28'h0, lvls[i], 1'b1, lvls[i], 1'b1});
    end
    xfer(1, ADDR_MODE, 32'h8000);
    repeat (3) @(posedge sys_clk);
    check("line B input", {31'h0, drive.line_b_oe}, 32'h0);
  endtask
  // Compare C: halt, clock off, trigger after each, restart of count
  task automatic testCmpC();
    xfer(1, ADDR_REGC, 32'h5);
    for (int i = 0; i < 2; i++)
    begin
      xfer(1, ADDR_MODE, i ? 32'h8080 : 32'h8040);
      xfer(1, ADDR_CTRL, 32'h5);
      repeat (40) @(posedge sys_clk);
      xfer(0, ADDR_COUNT, 0);
      check("stop at C", rdData, 32'h5);
      xfer(1, ADDR_CTRL, 32'h4);
      repeat (4) @(posedge sys_clk);
      xfer(0, ADDR_COUNT, 0);
      check("trigger after C", {31'h0, rdData == 32'h0}, {31'h0, i == 1});
    end
    xfer(1, ADDR_MODE, 32'h4000);
    xfer(1, ADDR_CTRL, 32'h5);
    for (int i = 0; i < 6; i++)
    begin
      xfer(0, ADDR_COUNT, 0);
      check("restart at C", {31'h0, rdData <= 5}, 32'h1);
    end
  endtask
  // One count edge on external clock 0
  task automatic pulse0();
    u_tcm_pins_model.setPin(0, 1'b1);
    u_tcm_pins_model.setPin(0, 1'b0);
  endtask
  // Capture mode: loads on line A edges, trigger from a rising edge of line B
  task automatic testCapture();
    xfer(1, ADDR_MODE, 32'h0009_0105);
    xfer(1, ADDR_CTRL, 32'h5);
    pulse0();
    u_tcm_pins_model.setPin(3, 1'b1);
    pulse0();
    u_tcm_pins_model.setPin(3, 1'b0);
    xfer(1, ADDR_REGA, 32'h7);
    xfer(0, ADDR_REGA, 0);
    a = rdData;
    xfer(0, ADDR_REGB, 0);
    b = rdData;
    check("load A", a, 32'h1);
    check("load B", b, 32'h2);
    u_tcm_pins_model.setPin(4, 1'b1);
    xfer(0, ADDR_COUNT, 0);
    check("trigger rise", rdData, 32'h0);
    pulse0();
    u_tcm_pins_model.setPin(4, 1'b0);
    u_tcm_pins_model.setPin(3, 1'b1);
    xfer(0, ADDR_COUNT, 0);
    check("no trigger", rdData, 32'h1);
  endtask
  // Waveform mode: event on clock 1 with and without restart, then match B on line B
  task automatic testEvent();
    for (int i = 0; i < 2; i++)
    begin
      xfer(1, ADDR_MODE, i ? 32'h0130_8905 : 32'h0130_9905);
      xfer(1, ADDR_CTRL, 32'h5);
      pulse0();
      u_tcm_pins_model.setPin(1, 1'b1);
      xfer(0, ADDR_COUNT, 0);
      check("event restart", rdData, {31'h0, i == 1});
      check("event line A", {31'h0, drive.line_a_out}, {31'h0, i == 0});
      u_tcm_pins_model.setPin(1, 1'b0);
      check("event fall", {31'h0, drive.line_a_out}, {31'h0, i == 0});
    end
    check("line B idle", {31'h0, drive.line_b_out}, 32'h0);
    pulse0();
    pulse0();
    check("match B", {31'h0, drive.line_b_out}, 32'h1);
  endtask
  // Watchdog
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end
  // Main sequence
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    testRegs();
    testRate();
    testExt();
    testLines();
    testCmpC();
    testCapture();
    testEvent();
    summarize();
  end
endmodule
